// ===== logic/uart_status_flags_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial status block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef UART_STATUS_FLAGS_PARAMS_SVH
`define UART_STATUS_FLAGS_PARAMS_SVH

// Register byte offsets
`define STATUS_OFF        12'h000
`define DATA_OFF          12'h004
`define CTRL_OFF          12'h008
`define BAUD_OFF          12'h00c

// Status bit positions
`define ST_TX_EMPTY       7
`define ST_TX_DONE        6
`define ST_RX_FULL        5
`define ST_IDLE           4
`define ST_OVERRUN        3
`define ST_NOISE          2
`define ST_FRAMING        1
`define ST_PARITY         0

// Control bit positions
`define CTL_PARITY_ODD    0
`define CTL_PARITY_EN     1
`define CTL_IDLE_SEL      2
`define CTL_LONG_CHAR     3
`define CTL_BREAK         4
`define CTL_TX_EN         5
`define CTL_RX_EN         6

// Reset values
`define STATUS_RESET      8'hc0
`define CTRL_RESET        7'h00
`define BAUD_RESET        16'h000c

// Oversampling: 16 samples per bit time
`define SUB_LAST          4'hf
`define START_SMP_FIRST   4'h4
`define START_SMP_LAST    4'ha
`define DATA_SMP_FIRST    4'h7
`define DATA_SMP_LAST     4'h9
`define START_QUORUM      3'h4
`define DATA_QUORUM       3'h2
`define START_SAMPLES     3'h7
`define DATA_SAMPLES      3'h3

// Bit counts per character
`define DATA_LAST_SHORT   4'h7
`define DATA_LAST_LONG    4'h8
`define FRAME_LAST_SHORT  4'h9
`define FRAME_LAST_LONG   4'ha
`define IDLE_BITS_SHORT   4'ha
`define IDLE_BITS_LONG    4'hb

`endif

// ===== logic/uart_status_flags_pkg.sv
// Purpose: Types of the serial status block
// Assumes: Nothing
// Notes:   Constants live in the params header
package uart_status_flags_pkg;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} tx_state_t;
endpackage

// ===== logic/uart_status_flags.sv
// Purpose: Serial port with status flags and their read-then-access clear sequences
// Assumes: rxd_in synchronous to clk_sys_in; 16x oversampling from baud divider
// Notes:   APB slave, one wait state per access
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "uart_status_flags_params.svh"

module uart_status_flags (
	input  wire logic        clk_sys_in,
	input  wire logic        nrst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rxd_in,
	output logic             txd_out
);
	import uart_status_flags_pkg::*;

	logic            pready_ff;
	logic [31:0]     prdata_ff;
	logic            pslverr_ff;
	logic [6:0]      ctrl_ff;
	logic [15:0]     baud_div_ff;
	logic [15:0]     baud_cnt_ff;
	logic [7:0]      flag_ff;
	logic [7:0]      arm_ff;
	logic [7:0]      flag_set;
	logic [7:0]      flag_clr;
	logic [31:0]     rd_val;
	logic            hit;
	logic            acc_cap;
	logic            acc_done;
	logic            status_rd_cap;
	logic            data_wr;
	logic            data_rd;
	logic            ctrl_wr;
	logic            baud_wr;
	logic            tx_en_rise;
	logic            brk_wr;
	logic            tick;
	logic            long_char;
	rx_state_t       rx_state_ff;
	logic [3:0]      rx_sub_ff;
	logic [3:0]      rx_bit_ff;
	logic [2:0]      rx_ones_ff;
	logic [8:0]      rx_shift_ff;
	logic            rx_noise_ff;
	logic [8:0]      rx_data_ff;
	logic [3:0]      idle_cnt_ff;
	logic            idle_armed_ff;
	logic            sample_pt;
	logic            bit_end;
	logic            maj;
	logic            bit_noisy;
	logic            frame_done;
	logic            rx_accept;
	logic            rx_overrun;
	logic [8:0]      rx_word;
	logic            parity_bad;
	logic            line_high;
	logic [3:0]      idle_target;
	logic            idle_hit;
	tx_state_t       tx_state_ff;
	logic [3:0]      tx_sub_ff;
	logic [3:0]      tx_left_ff;
	logic [10:0]     tx_shift_ff;
	logic            txd_ff;
	logic [8:0]      tx_buf_ff;
	logic            buf_full_ff;
	logic            pend_pre_ff;
	logic            pend_brk_ff;
	logic            tx_free;
	logic            tx_load_pre;
	logic            tx_load_brk;
	logic            tx_load_data;
	logic            tx_queue_now;
	logic            done_cond;
	logic [8:0]      tx_word;
	logic [10:0]     tx_frame;

	assign prdata_out  = prdata_ff;
	assign pready_out  = pready_ff;
	assign pslverr_out = pslverr_ff;
	assign txd_out     = txd_ff;
	assign long_char   = ctrl_ff[`CTL_LONG_CHAR];

	// APB decode
	assign acc_cap       = psel_in & penable_in & ~pready_ff;
	assign acc_done      = psel_in & penable_in & pready_ff;
	assign status_rd_cap = acc_cap & ~pwrite_in & (paddr_in == `STATUS_OFF);
	assign data_wr       = acc_done & pwrite_in & (paddr_in == `DATA_OFF);
	assign data_rd       = acc_done & ~pwrite_in & (paddr_in == `DATA_OFF);
	assign ctrl_wr       = acc_done & pwrite_in & (paddr_in == `CTRL_OFF);
	assign baud_wr       = acc_done & pwrite_in & (paddr_in == `BAUD_OFF);
	assign tx_en_rise    = ctrl_wr & pwdata_in[`CTL_TX_EN] & ~ctrl_ff[`CTL_TX_EN];
	assign brk_wr        = ctrl_wr & pwdata_in[`CTL_BREAK];

	always_comb begin
		rd_val = 32'h0;
		hit    = 1'b1;
		if (paddr_in == `STATUS_OFF) begin
			rd_val = {24'h0, flag_ff};
		end else if (paddr_in == `DATA_OFF) begin
			rd_val = {23'h0, rx_data_ff};
		end else if (paddr_in == `CTRL_OFF) begin
			rd_val = {25'h0, ctrl_ff};
		end else if (paddr_in == `BAUD_OFF) begin
			rd_val = {16'h0, baud_div_ff};
		end else begin
			hit = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= acc_cap;
			pslverr_ff <= acc_cap & ~hit;
			if (acc_cap) begin
				prdata_ff <= pwrite_in ? 32'h0 : rd_val;
			end
		end
	end

	// Status writes fall through: no register takes them
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_ff     <= `CTRL_RESET;
			baud_div_ff <= `BAUD_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl_ff <= pwdata_in[6:0];
			end
			if (baud_wr) begin
				baud_div_ff <= pwdata_in[15:0];
			end
		end
	end

	// Clear sequences
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			arm_ff <= 8'h00;
		end else if (status_rd_cap) begin
			arm_ff <= flag_ff;
		end else begin
			if (data_wr) begin
				arm_ff[7:6] <= 2'b00;
			end
			if (tx_en_rise | brk_wr) begin
				arm_ff[`ST_TX_DONE] <= 1'b0;
			end
			if (data_rd) begin
				arm_ff[5:0] <= 6'h00;
			end
		end
	end

	always_comb begin
		flag_clr                = 8'h00;
		flag_clr[`ST_TX_EMPTY]  = data_wr & arm_ff[`ST_TX_EMPTY];
		flag_clr[`ST_TX_DONE]   = arm_ff[`ST_TX_DONE] & (data_wr | tx_en_rise | brk_wr);
		flag_clr[5:0]           = data_rd ? arm_ff[5:0] : 6'h00;
		flag_set                = 8'h00;
		flag_set[`ST_TX_EMPTY]  = tx_load_data;
		flag_set[`ST_TX_DONE]   = done_cond & ~tx_queue_now;
		flag_set[`ST_RX_FULL]   = rx_accept;
		flag_set[`ST_IDLE]      = idle_hit;
		flag_set[`ST_OVERRUN]   = rx_overrun;
		flag_set[`ST_NOISE]     = rx_accept & (rx_noise_ff | bit_noisy);
		flag_set[`ST_FRAMING]   = rx_accept & ~maj;
		flag_set[`ST_PARITY]    = rx_accept & ctrl_ff[`CTL_PARITY_EN] & parity_bad;
	end

	// Set wins over clear
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flag_ff <= `STATUS_RESET;
		end else begin
			flag_ff <= flag_set | (flag_ff & ~flag_clr);
		end
	end

	// Baud tick at 16x bit rate
	assign tick = (baud_cnt_ff == 16'h0);

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			baud_cnt_ff <= 16'h0;
		end else begin
			baud_cnt_ff <= tick ? baud_div_ff : baud_cnt_ff - 16'h1;
		end
	end

	// Receiver
	assign sample_pt  = (rx_state_ff == RX_START) ?
		(rx_sub_ff >= `START_SMP_FIRST && rx_sub_ff <= `START_SMP_LAST) :
		(rx_sub_ff >= `DATA_SMP_FIRST && rx_sub_ff <= `DATA_SMP_LAST);
	assign bit_end    = tick & (rx_sub_ff == `SUB_LAST);
	assign maj        = (rx_ones_ff >= `DATA_QUORUM);
	assign bit_noisy  = (rx_ones_ff != 3'h0) && (rx_ones_ff != `DATA_SAMPLES);
	assign frame_done = bit_end & (rx_state_ff == RX_STOP);
	assign rx_accept  = frame_done & ~flag_ff[`ST_RX_FULL];
	assign rx_overrun = frame_done & flag_ff[`ST_RX_FULL];
	assign rx_word    = long_char ? rx_shift_ff : {1'b0, rx_shift_ff[8:1]};
	assign parity_bad = (^rx_word) != ctrl_ff[`CTL_PARITY_ODD];

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_state_ff <= RX_IDLE;
			rx_sub_ff   <= 4'h0;
			rx_bit_ff   <= 4'h0;
			rx_ones_ff  <= 3'h0;
			rx_shift_ff <= 9'h0;
			rx_noise_ff <= 1'b0;
		end else if (!ctrl_ff[`CTL_RX_EN]) begin
			// Parked sub count keeps bit_end from firing every tick
			rx_state_ff <= RX_IDLE;
			rx_sub_ff   <= 4'h0;
			rx_ones_ff  <= 3'h0;
		end else if (tick) begin
			rx_sub_ff <= rx_sub_ff + 4'h1;
			if (bit_end) begin
				rx_ones_ff <= 3'h0;
			end else if (sample_pt) begin
				rx_ones_ff <= rx_ones_ff + {2'b00, rxd_in};
			end
			case (rx_state_ff)
				RX_IDLE: begin
					if (!rxd_in) begin
						rx_state_ff <= RX_START;
						rx_sub_ff   <= 4'h1;
						rx_ones_ff  <= 3'h0;
					end
				end
				RX_START: begin
					if (bit_end) begin
						rx_state_ff <= (rx_ones_ff >= `START_QUORUM) ? RX_IDLE : RX_DATA;
						rx_bit_ff   <= 4'h0;
						rx_noise_ff <= (rx_ones_ff != 3'h0) && (rx_ones_ff != `START_SAMPLES);
					end
				end
				RX_DATA: begin
					if (bit_end) begin
						rx_shift_ff <= {maj, rx_shift_ff[8:1]};
						rx_noise_ff <= rx_noise_ff | bit_noisy;
						rx_bit_ff   <= rx_bit_ff + 4'h1;
						if (rx_bit_ff == (long_char ? `DATA_LAST_LONG : `DATA_LAST_SHORT)) begin
							rx_state_ff <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (bit_end) begin
						rx_state_ff <= RX_IDLE;
					end
				end
				default: begin
					rx_state_ff <= RX_IDLE;
				end
			endcase
		end
	end

	// Overrun leaves the held character untouched
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_data_ff <= 9'h0;
		end else if (rx_accept) begin
			rx_data_ff <= rx_word;
		end
	end

	// Idle line detection
	assign idle_target = long_char ? `IDLE_BITS_LONG : `IDLE_BITS_SHORT;

	always_comb begin
		case (rx_state_ff)
			RX_IDLE:  line_high = rxd_in;
			RX_START: line_high = 1'b0;
			default:  line_high = maj & ~ctrl_ff[`CTL_IDLE_SEL];
		endcase
	end

	assign idle_hit = bit_end & line_high & idle_armed_ff & (idle_cnt_ff == idle_target - 4'h1);

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			idle_cnt_ff   <= 4'h0;
			idle_armed_ff <= 1'b0;
		end else begin
			if (bit_end) begin
				if (!line_high) begin
					idle_cnt_ff <= 4'h0;
				end else if (idle_cnt_ff != idle_target) begin
					idle_cnt_ff <= idle_cnt_ff + 4'h1;
				end
			end
			if (rx_accept) begin
				idle_armed_ff <= 1'b1;
			end else if (idle_hit) begin
				idle_armed_ff <= 1'b0;
			end
		end
	end

	// Transmitter: preamble before break before data
	assign tx_free      = (tx_state_ff == TX_IDLE) & ctrl_ff[`CTL_TX_EN];
	assign tx_load_pre  = tx_free & pend_pre_ff;
	assign tx_load_brk  = tx_free & ~pend_pre_ff & (pend_brk_ff | ctrl_ff[`CTL_BREAK]);
	assign tx_load_data = tx_free & ~pend_pre_ff & ~pend_brk_ff & ~ctrl_ff[`CTL_BREAK] & buf_full_ff;
	assign tx_queue_now = data_wr | tx_en_rise | brk_wr;
	assign done_cond    = ~buf_full_ff & (tx_state_ff == TX_IDLE) & ~pend_pre_ff & ~pend_brk_ff
		& ~ctrl_ff[`CTL_BREAK];

	always_comb begin
		tx_word = tx_buf_ff;
		if (ctrl_ff[`CTL_PARITY_EN]) begin
			if (long_char) begin
				tx_word[8] = (^tx_buf_ff[7:0]) ^ ctrl_ff[`CTL_PARITY_ODD];
			end else begin
				tx_word[7] = (^tx_buf_ff[6:0]) ^ ctrl_ff[`CTL_PARITY_ODD];
			end
		end
		if (tx_load_pre) begin
			tx_frame = 11'h7ff;
		end else if (tx_load_brk) begin
			tx_frame = 11'h000;
		end else if (long_char) begin
			tx_frame = {1'b1, tx_word, 1'b0};
		end else begin
			tx_frame = {2'b11, tx_word[7:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_state_ff <= TX_IDLE;
			tx_sub_ff   <= 4'h0;
			tx_left_ff  <= 4'h0;
			tx_shift_ff <= 11'h7ff;
			txd_ff      <= 1'b1;
		end else begin
			case (tx_state_ff)
				TX_IDLE: begin
					txd_ff <= 1'b1;
					if (tx_load_pre | tx_load_brk | tx_load_data) begin
						tx_state_ff <= TX_SEND;
						tx_sub_ff   <= 4'h0;
						tx_left_ff  <= long_char ? `FRAME_LAST_LONG : `FRAME_LAST_SHORT;
						txd_ff      <= tx_frame[0];
						tx_shift_ff <= {1'b1, tx_frame[10:1]};
					end
				end
				TX_SEND: begin
					if (tick) begin
						tx_sub_ff <= tx_sub_ff + 4'h1;
						if (tx_sub_ff == `SUB_LAST) begin
							if (tx_left_ff == 4'h0) begin
								tx_state_ff <= TX_IDLE;
								txd_ff      <= 1'b1;
							end else begin
								txd_ff      <= tx_shift_ff[0];
								tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
								tx_left_ff  <= tx_left_ff - 4'h1;
							end
						end
					end
				end
				default: begin
					tx_state_ff <= TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_buf_ff   <= 9'h0;
			buf_full_ff <= 1'b0;
			pend_pre_ff <= 1'b0;
			pend_brk_ff <= 1'b0;
		end else begin
			if (data_wr) begin
				tx_buf_ff   <= pwdata_in[8:0];
				buf_full_ff <= 1'b1;
			end else if (tx_load_data) begin
				buf_full_ff <= 1'b0;
			end
			if (tx_en_rise) begin
				pend_pre_ff <= 1'b1;
			end else if (tx_load_pre) begin
				pend_pre_ff <= 1'b0;
			end
			if (brk_wr) begin
				pend_brk_ff <= 1'b1;
			end else if (tx_load_brk) begin
				pend_brk_ff <= 1'b0;
			end
		end
	end

	property p_txe_clr;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$fell(flag_ff[7]) |-> $past(data_wr && arm_ff[7]);
	endproperty
	a_txe_clr: assert property (p_txe_clr) else $error("tx empty cleared without sequence");

	property p_txe_set;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		tx_load_data |=> flag_ff[7] && (tx_state_ff == TX_SEND);
	endproperty
	a_txe_set: assert property (p_txe_set) else $error("tx empty not set on load");

	property p_txdone_set;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		done_cond && !tx_queue_now |=> flag_ff[6];
	endproperty
	a_txdone_set: assert property (p_txdone_set) else $error("tx complete not set when idle");

	property p_txdone_clr;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$fell(flag_ff[6]) |-> $past(arm_ff[6] && (data_wr || tx_en_rise || brk_wr));
	endproperty
	a_txdone_clr: assert property (p_txdone_clr) else $error("tx complete cleared without sequence");

	property p_rxfull_set;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		rx_accept |=> flag_ff[5] && (rx_data_ff == $past(rx_word));
	endproperty
	a_rxfull_set: assert property (p_rxfull_set) else $error("rx full not set with data");

	property p_rxfull_clr;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$fell(flag_ff[5]) |-> $past(data_rd && arm_ff[5]);
	endproperty
	a_rxfull_clr: assert property (p_rxfull_clr) else $error("rx full cleared without sequence");

	property p_overrun;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		rx_overrun |=> flag_ff[3] && $stable(rx_data_ff);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged or data lost");

	property p_idle_once;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$rose(flag_ff[4]) |-> $past(idle_armed_ff) && !idle_armed_ff;
	endproperty
	a_idle_once: assert property (p_idle_once) else $error("idle set without new character");

	property p_framing;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		rx_accept && !maj |=> flag_ff[1] && flag_ff[5];
	endproperty
	a_framing: assert property (p_framing) else $error("framing error missed");

	property p_txdone_idle;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$rose(flag_ff[6]) |-> (tx_state_ff == TX_IDLE) && !buf_full_ff && txd_ff;
	endproperty
	a_txdone_idle: assert property (p_txdone_idle) else $error("tx complete set while sending");
endmodule

// ===== testbench/remote_node.sv
// Purpose: Remote serial node on the far side of the line
// Assumes: 16 clocks per bit time (baud divisor 0), eight or nine data bits sent, eight decoded
// Notes:   Sends frames on rxd, decodes frames seen on txd into got_q
`timescale 1ns/1ps

module remote_node (
	input  wire logic clk_in,
	input  wire logic txd_in,
	output logic      rxd_out
);
	logic [7:0] got_q[$];
	logic [7:0] word;

	initial begin
		rxd_out = 1'b1;
	end

	// Start, nd data bits LSB first, stop; optional one-cycle glitch in first data bit
	task automatic send_frame(input logic [8:0] data, input int nd, input logic stop_bit, input logic glitch);
		logic [10:0] bits;
		bits         = {1'b1, data, 1'b0};
		bits[nd + 1] = stop_bit;
		for (int i = 0; i < nd + 2; i++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge clk_in);
				rxd_out <= (glitch && i == 1 && c == 9) ? ~bits[i] : bits[i];
			end
		end
		@(posedge clk_in);
		rxd_out <= 1'b1;
	endtask

	// Mid-bit sampling of transmitted frames
	initial begin
		forever begin
			@(negedge txd_in);
			repeat (8) @(posedge clk_in);
			if (txd_in === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (16) @(posedge clk_in);
					word[i] = txd_in;
				end
				repeat (16) @(posedge clk_in);
				got_q.push_back(word);
			end
		end
	end
endmodule

// ===== testbench/uart_status_flags_tb.sv
// Purpose: Self-checking bench for the serial status flags over APB
// Assumes: Baud divisor written to 0, so one bit time is 16 clocks
// Notes:   Flags cleared by status read then data access
`timescale 1ns/1ps
`include "uart_status_flags_params.svh"

module uart_status_flags_tb;
	logic        clk_sys;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic [31:0] rd;
	logic        err;
	int          num_errors;
	int          n_tests;
	logic [7:0]  par_data [2] = '{8'h01, 8'h81};
	logic [31:0] par_exp [4]  = '{32'he1, 32'he0, 32'he0, 32'he1};

	uart_status_flags dut (
		.clk_sys_in  (clk_sys),
		.nrst_in     (nrst),
		.psel_in     (psel),
		.penable_in  (penable),
		.pwrite_in   (pwrite),
		.paddr_in    (paddr),
		.pwdata_in   (pwdata),
		.prdata_out  (prdata),
		.pready_out  (pready),
		.pslverr_out (pslverr),
		.rxd_in      (rxd),
		.txd_out     (txd)
	);

	remote_node u_node (
		.clk_in  (clk_sys),
		.txd_in  (txd),
		.rxd_out (rxd)
	);

	always #20 clk_sys = ~clk_sys;

	task automatic print_verdict();
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(rd, exp);
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Let idle settle, then run the full clear sequence
	task automatic drain();
		wait_clk(300);
		apb(1'b0, `STATUS_OFF, 32'h0);
		apb(1'b0, `DATA_OFF, 32'h0);
	endtask

	task automatic rx_char(input logic [7:0] d, input logic stop_bit, input logic glitch);
		u_node.send_frame({1'b0, d}, 8, stop_bit, glitch);
		wait_clk(20);
	endtask

	initial begin
		wait_clk(30000);
		num_errors++;
		print_verdict();
	end

	initial begin
		clk_sys = 1'b0;
		nrst    = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		num_errors = 0;
		n_tests    = 0;
		wait_clk(6);
		nrst <= 1'b1;
		rdchk(`STATUS_OFF, 32'hc0);
		rdchk(`CTRL_OFF, 32'h0);
		rdchk(`BAUD_OFF, 32'hc);
		rdchk(12'h010, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, `STATUS_OFF, 32'hffffffff);
		chk({31'h0, err}, 32'h0);
		rdchk(`STATUS_OFF, 32'hc0);
		apb(1'b1, `BAUD_OFF, 32'h0);
		apb(1'b1, `CTRL_OFF, 32'h60);
		rdchk(`STATUS_OFF, 32'h80);
		wait_clk(300);
		rdchk(`STATUS_OFF, 32'hc0);
		apb(1'b1, `DATA_OFF, 32'ha5);
		rdchk(`STATUS_OFF, 32'h80);
		apb(1'b1, `DATA_OFF, 32'h3c);
		rdchk(`STATUS_OFF, 32'h00);
		wait_clk(400);
		rdchk(`STATUS_OFF, 32'hc0);
		chk(u_node.got_q.size(), 32'h2);
		chk({24'h0, u_node.got_q[0]}, 32'ha5);
		chk({24'h0, u_node.got_q[1]}, 32'h3c);
		apb(1'b1, `CTRL_OFF, 32'h70);
		rdchk(`STATUS_OFF, 32'h80);
		apb(1'b1, `CTRL_OFF, 32'h60);
		wait_clk(500);
		rdchk(`STATUS_OFF, 32'hc0);
		rx_char(8'h5a, 1'b1, 1'b0);
		rdchk(`STATUS_OFF, 32'he0);
		wait_clk(200);
		rdchk(`STATUS_OFF, 32'hf0);
		rdchk(`DATA_OFF, 32'h5a);
		rdchk(`STATUS_OFF, 32'hc0);
		wait_clk(400);
		rdchk(`STATUS_OFF, 32'hc0);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, `CTRL_OFF, 32'h60 | (s << 2));
			rx_char(8'hff, 1'b1, 1'b0);
			wait_clk(28);
			rdchk(`STATUS_OFF, (s == 1) ? 32'he0 : 32'hf0);
			rdchk(`DATA_OFF, 32'hff);
		end
		wait_clk(300);
		rdchk(`STATUS_OFF, 32'hd0);
		rdchk(`DATA_OFF, 32'hff);
		rdchk(`STATUS_OFF, 32'hc0);
		apb(1'b1, `CTRL_OFF, 32'h60);
		rx_char(8'h11, 1'b1, 1'b0);
		rdchk(`DATA_OFF, 32'h11);
		rdchk(`STATUS_OFF, 32'he0);
		rx_char(8'h33, 1'b1, 1'b0);
		rdchk(`STATUS_OFF, 32'he8);
		rdchk(`DATA_OFF, 32'h11);
		rdchk(`STATUS_OFF, 32'hc0);
		drain();
		rx_char(8'h22, 1'b0, 1'b0);
		rdchk(`STATUS_OFF, 32'he2);
		rdchk(`DATA_OFF, 32'h22);
		rdchk(`STATUS_OFF, 32'hc0);
		drain();
		rx_char(8'h22, 1'b1, 1'b1);
		rdchk(`STATUS_OFF, 32'he4);
		rdchk(`DATA_OFF, 32'h22);
		rdchk(`STATUS_OFF, 32'hc0);
		drain();
		// Nine data bits, idle counted after stop: 11 bit times, not 10
		apb(1'b1, `CTRL_OFF, 32'h6c);
		u_node.send_frame(9'h1ff, 9, 1'b1, 1'b0);
		wait_clk(165);
		rdchk(`STATUS_OFF, 32'he0);
		wait_clk(20);
		rdchk(`STATUS_OFF, 32'hf0);
		rdchk(`DATA_OFF, 32'h1ff);
		rdchk(`STATUS_OFF, 32'hc0);
		// Even parity first, then odd
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `CTRL_OFF, 32'h62 | (k >> 1));
			drain();
			rx_char(par_data[k % 2], 1'b1, 1'b0);
			rdchk(`STATUS_OFF, par_exp[k]);
			apb(1'b0, `DATA_OFF, 32'h0);
			rdchk(`STATUS_OFF, 32'hc0);
		end
		print_verdict();
	end
endmodule
